// *** logic/susc_pkg.sv ***
// Package for the serial unit control and status block: offsets, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
package susc_pkg;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CONTROL_ONE   = 8'h00;
  localparam logic [7:0] ADDR_RATE_LOW      = 8'h04;
  localparam logic [7:0] ADDR_RATE_HIGH     = 8'h08;
  localparam logic [7:0] ADDR_STATUS        = 8'h0C;
  localparam logic [7:0] ADDR_RX_BUFFER     = 8'h10;
  localparam logic [7:0] ADDR_TX_BUFFER     = 8'h14;
  localparam logic [7:0] ADDR_PAIR0_ENABLE  = 8'h18;
  localparam logic [7:0] ADDR_PAIR0_FLAG    = 8'h1C;
  localparam logic [7:0] ADDR_PAIR1_ENABLE  = 8'h20;
  localparam logic [7:0] ADDR_PAIR1_FLAG    = 8'h24;
  localparam logic [7:0] ADDR_MODE_CONFIG   = 8'h28;
  localparam logic [7:0] ADDR_EVENT_STATUS  = 8'h2C;
  localparam logic [7:0] ADDR_EVENT_MASK    = 8'h30;

  // Control one fields.
  localparam int CTL_SRC_HI    = 7;
  localparam int CTL_SRC_LO    = 6;
  localparam int CTL_SOFT_RST  = 0;
  localparam logic [7:0] CONTROL_ONE_RESET = 8'h01;
  localparam logic [1:0] SRC_AUX      = 2'h1;
  localparam logic [1:0] SRC_SUB_MAIN = 2'h2;
  localparam logic [1:0] SRC_SUB_ALT  = 2'h3;

  // Status fields.
  localparam int STAT_LOOPBACK = 7;
  localparam int STAT_FRAMING  = 6;
  localparam int STAT_OVERRUN  = 5;
  localparam int STAT_BUSY     = 0;

  // Mode configuration fields.
  localparam int CFG_MASTER    = 0;
  localparam int CFG_SEVEN_BIT = 1;
  localparam int CFG_FOUR_WIRE = 2;
  localparam int CFG_MSB_FIRST = 3;

  // Interrupt flag register reset: transmit flags set, receive flags clear.
  localparam logic [3:0] PAIR_FLAG_RESET = 4'hA;
  localparam int SLOT_OWN_RX = 0;
  localparam int SLOT_OWN_TX = 1;

  // Event status bits.
  localparam int EVT_RX_DONE   = 0;
  localparam int EVT_TX_EMPTY  = 1;
  localparam int EVT_OVERRUN   = 2;
  localparam int EVT_FRAMING   = 3;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    ENG_IDLE = 1'b0,
    ENG_RUN  = 1'b1
  } susc_eng_t;

endpackage : susc_pkg

// *** logic/susc_top.sv ***
// Serial unit in SPI mode with its control, status, buffer and interrupt registers.
// Assumes one 100 MHz clock; clock source and serial pins arrive asynchronously.
// Overview of operation
// - Master mode: source field code 01 picks auxiliary clock, 10 and 11 sub-main.
// - Slave mode ignores the source field and shifts on the external serial clock.
// - Soft reset bit 0 of control one holds the serial logic while set.
// - Prescaler is low byte plus high byte times 256; divides the selected source.
// - Loopback bit 7 routes the transmitter output to the receiver input.
// - Framing error bit 6 flags a bus conflict in 4-wire master mode only.
// - Overrun bit 5 sets when a character lands before the previous was read.
// - Reading the receive buffer clears overrun; software must not clear it.
// - Busy bit 0 reads one while a transfer is in progress.
// - Receive buffer holds the last character; reading clears errors and receive flag.
// - Seven-bit mode stores received characters right-justified with bit 7 zero.
// - Writing the transmit buffer loads the next byte and clears the transmit flag.
// - Seven-bit mode leaves transmit buffer bit 7 unused and reading zero.
// - Pair 0 enables: second unit tx/rx at bits 3/2, first unit at 1/0.
// - Bits 7-4 of pair 0 enable and flag registers are left untouched.
// - Transmit flags set whenever their buffer is empty, reset value one.
// - Receive flags set on a complete character, reset value zero.
// - Pair 1 has its own enable and flag registers, same layout, bits 7-4 unused.
`timescale 1ns/1ns
module susc_top
  import susc_pkg::*;
#(
  parameter int PRESCALE_W = 16
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        auxClkIn,
  input  wire logic        subMainClkIn,
  input  wire logic        serialClkIn,
  output logic             serialClkOut,
  output logic             serialClkOe,
  input  wire logic        slaveEnableInN,
  input  wire logic        serialDataIn,
  output logic             serialDataOut,
  output logic             serialDataOe,
  input  wire logic [7:0]  otherRxDone,
  input  wire logic [7:0]  otherTxEmpty,
  output logic [7:0]       unitIrq,
  output logic             irq
);

  if (PRESCALE_W != 16) begin : gCheck
    $error("PRESCALE_W must be 16.");
  end

  // Pin synchronisers: bit 4 aux, 3 sub-main, 2 serial clock, 1 enable, 0 data.
  logic [4:0] pinS1_q;
  logic [4:0] pinS2_q;
  logic [4:0] pinS3_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinS1_q <= 5'h02;
      pinS2_q <= 5'h02;
      pinS3_q <= 5'h02;
    end else begin
      pinS1_q <= {auxClkIn, subMainClkIn, serialClkIn, slaveEnableInN, serialDataIn};
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
    end
  end

  // Registers.
  logic [7:0]      controlOne_q;
  logic [7:0]      rateLow_q;
  logic [7:0]      rateHigh_q;
  logic            loopback_q;
  logic            framingErr_q;
  logic            overrunErr_q;
  logic [7:0]      rxBuffer_q;
  logic            rxFull_q;
  logic [7:0]      txBuffer_q;
  logic            txFull_q;
  logic [3:0]      modeConfig_q;
  logic [7:0]      intEnable_q;
  logic [7:0]      intFlag_q;
  logic [3:0]      evtStatus_q;
  logic [3:0]      evtMask_q;
  susc_eng_t       engState_q;
  logic            phase_q;
  logic [2:0]      bitCnt_q;
  logic [15:0]     divCnt_q;
  logic [7:0]      txShift_q;
  logic [7:0]      rxShift_q;

  // Bus handshake.
  logic wrFire;
  logic rdFire;
  logic wrEn;
  assign wrFire = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  assign rdFire = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  assign wrEn   = wrFire && s_axi_wstrb[0];

  logic [7:0] wByte;
  assign wByte = s_axi_wdata[7:0];

  logic wrCtl;
  logic wrStat;
  logic wrTx;
  logic rdRx;
  assign wrCtl  = wrEn && (s_axi_awaddr == ADDR_CONTROL_ONE);
  assign wrStat = wrEn && (s_axi_awaddr == ADDR_STATUS);
  assign wrTx   = wrEn && (s_axi_awaddr == ADDR_TX_BUFFER);
  assign rdRx   = rdFire && (s_axi_araddr == ADDR_RX_BUFFER);

  // Mode decode.
  logic softRst;
  logic isMaster;
  logic sevenBit;
  logic fourWire;
  logic msbFirst;
  assign softRst  = controlOne_q[CTL_SOFT_RST];
  assign isMaster = modeConfig_q[CFG_MASTER];
  assign sevenBit = modeConfig_q[CFG_SEVEN_BIT];
  assign fourWire = modeConfig_q[CFG_FOUR_WIRE];
  assign msbFirst = modeConfig_q[CFG_MSB_FIRST];

  // Source tick and prescaler.
  logic [1:0]  srcSel;
  logic        srcTick;
  logic [15:0] divisor;
  logic        halfTick;
  assign srcSel = controlOne_q[CTL_SRC_HI:CTL_SRC_LO];
  always_comb begin
    case (srcSel)
      SRC_AUX:      srcTick = pinS2_q[4] && !pinS3_q[4];
      SRC_SUB_MAIN: srcTick = pinS2_q[3] && !pinS3_q[3];
      SRC_SUB_ALT:  srcTick = pinS2_q[3] && !pinS3_q[3];
      default:      srcTick = 1'b0;
    endcase
  end
  assign divisor  = ({rateHigh_q, 8'h00} + {8'h00, rateLow_q} == 16'h0000) ? 16'h0001
                    : {rateHigh_q, 8'h00} + {8'h00, rateLow_q};
  assign halfTick = srcTick && (divCnt_q == divisor - 16'h0001);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      divCnt_q <= 16'h0000;
    end else if (softRst || engState_q == ENG_IDLE) begin
      divCnt_q <= 16'h0000;
    end else if (halfTick) begin
      divCnt_q <= 16'h0000;
    end else if (srcTick) begin
      divCnt_q <= divCnt_q + 16'h0001;
    end
  end

  // Shift events: master from the prescaler, slave from the external clock.
  logic slaveSel;
  logic sampleEv;
  logic shiftEv;
  logic lastBit;
  logic txBit;
  logic rxBit;
  logic [7:0] rxResult;
  assign slaveSel = !fourWire || !pinS2_q[1];
  assign sampleEv = isMaster ? (engState_q == ENG_RUN && halfTick && !phase_q)
                    : (slaveSel && pinS2_q[2] && !pinS3_q[2]);
  assign shiftEv  = isMaster ? (engState_q == ENG_RUN && halfTick && phase_q)
                    : (slaveSel && !pinS2_q[2] && pinS3_q[2]);
  assign lastBit  = bitCnt_q == (sevenBit ? 3'h6 : 3'h7);
  assign txBit    = msbFirst ? (sevenBit ? txShift_q[6] : txShift_q[7]) : txShift_q[0];
  assign rxBit    = loopback_q ? txBit : pinS2_q[0];
  assign rxResult = !sevenBit ? rxShift_q
                    : (msbFirst ? {1'b0, rxShift_q[6:0]} : {1'b0, rxShift_q[7:1]});

  logic doneEv;
  logic loadEv;
  assign doneEv = !softRst && engState_q == ENG_RUN && shiftEv && lastBit;
  assign loadEv = !softRst && engState_q == ENG_IDLE && txFull_q;

  // Engine.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      engState_q <= ENG_IDLE;
      phase_q    <= 1'b0;
      bitCnt_q   <= 3'h0;
      txShift_q  <= 8'h00;
      rxShift_q  <= 8'h00;
    end else if (softRst) begin
      engState_q <= ENG_IDLE;
      phase_q    <= 1'b0;
      bitCnt_q   <= 3'h0;
    end else begin
      case (engState_q)
        ENG_IDLE: begin
          phase_q  <= 1'b0;
          bitCnt_q <= 3'h0;
          if (loadEv) begin
            txShift_q <= txBuffer_q;
          end
          if (isMaster && loadEv) begin
            engState_q <= ENG_RUN;
          end else if (!isMaster && sampleEv) begin
            engState_q <= ENG_RUN;
            rxShift_q  <= msbFirst ? {rxShift_q[6:0], rxBit} : {rxBit, rxShift_q[7:1]};
          end
        end
        ENG_RUN: begin
          if (sampleEv) begin
            phase_q   <= 1'b1;
            rxShift_q <= msbFirst ? {rxShift_q[6:0], rxBit} : {rxBit, rxShift_q[7:1]};
          end else if (shiftEv) begin
            phase_q   <= 1'b0;
            txShift_q <= msbFirst ? {txShift_q[6:0], 1'b0} : {1'b0, txShift_q[7:1]};
            bitCnt_q  <= bitCnt_q + 3'h1;
            if (lastBit) begin
              engState_q <= ENG_IDLE;
            end
          end
        end
        default: engState_q <= ENG_IDLE;
      endcase
    end
  end

  // Buffers and status.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txBuffer_q <= 8'h00;
      txFull_q   <= 1'b0;
    end else begin
      if (wrTx) begin
        txBuffer_q <= sevenBit ? {1'b0, wByte[6:0]} : wByte;
        txFull_q   <= 1'b1;
      end else if (loadEv) begin
        txFull_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxBuffer_q   <= 8'h00;
      rxFull_q     <= 1'b0;
      overrunErr_q <= 1'b0;
    end else begin
      if (doneEv) begin
        rxBuffer_q <= rxResult;
        rxFull_q   <= 1'b1;
        if (rxFull_q && !rdRx) begin
          overrunErr_q <= 1'b1;
        end
      end else if (rdRx) begin
        rxFull_q     <= 1'b0;
        overrunErr_q <= 1'b0;
      end
    end
  end

  logic conflictEv;
  assign conflictEv = !softRst && isMaster && fourWire && engState_q == ENG_RUN
                      && !pinS2_q[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loopback_q   <= 1'b0;
      framingErr_q <= 1'b0;
    end else begin
      if (wrStat) begin
        loopback_q <= wByte[STAT_LOOPBACK];
      end
      if (conflictEv) begin
        framingErr_q <= 1'b1;
      end else if (rdRx) begin
        framingErr_q <= 1'b0;
      end else if (wrStat) begin
        framingErr_q <= wByte[STAT_FRAMING];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      controlOne_q <= CONTROL_ONE_RESET;
      rateLow_q    <= 8'h00;
      rateHigh_q   <= 8'h00;
      modeConfig_q <= 4'h0;
      evtMask_q    <= 4'h0;
    end else if (wrEn) begin
      case (s_axi_awaddr)
        ADDR_CONTROL_ONE: controlOne_q <= {wByte[7:6], 5'h00, wByte[0]};
        ADDR_RATE_LOW:    rateLow_q    <= wByte;
        ADDR_RATE_HIGH:   rateHigh_q   <= wByte;
        ADDR_MODE_CONFIG: modeConfig_q <= wByte[3:0];
        ADDR_EVENT_MASK:  evtMask_q    <= wByte[3:0];
        default:          evtMask_q    <= evtMask_q;
      endcase
    end
  end

  // Interrupt enables and flags: bits 3:0 pair 0, bits 7:4 pair 1.
  logic [7:0] flagSet;
  logic [7:0] flagClr;
  always_comb begin
    flagSet = otherRxDone | otherTxEmpty;
    flagSet[SLOT_OWN_RX] = doneEv;
    flagSet[SLOT_OWN_TX] = !txFull_q && !wrTx;
    flagClr = 8'h00;
    flagClr[SLOT_OWN_RX] = rdRx;
    flagClr[SLOT_OWN_TX] = wrTx;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intEnable_q <= 8'h00;
    end else if (wrEn && s_axi_awaddr == ADDR_PAIR0_ENABLE) begin
      intEnable_q[3:0] <= wByte[3:0];
    end else if (wrEn && s_axi_awaddr == ADDR_PAIR1_ENABLE) begin
      intEnable_q[7:4] <= wByte[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intFlag_q <= {PAIR_FLAG_RESET, PAIR_FLAG_RESET};
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (flagSet[i]) begin
          intFlag_q[i] <= 1'b1;
        end else if (flagClr[i]) begin
          intFlag_q[i] <= 1'b0;
        end else if (wrEn && i < 4 && s_axi_awaddr == ADDR_PAIR0_FLAG) begin
          intFlag_q[i] <= wByte[i];
        end else if (wrEn && i >= 4 && s_axi_awaddr == ADDR_PAIR1_FLAG) begin
          intFlag_q[i] <= wByte[i % 4];
        end
      end
    end
  end

  // Event status, write one to clear, set wins.
  logic [3:0] evtSet;
  assign evtSet = {conflictEv, doneEv && rxFull_q && !rdRx, loadEv, doneEv};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evtStatus_q <= 4'h0;
    end else if (wrEn && s_axi_awaddr == ADDR_EVENT_STATUS) begin
      evtStatus_q <= (evtStatus_q & ~wByte[3:0]) | evtSet;
    end else begin
      evtStatus_q <= evtStatus_q | evtSet;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq     <= 1'b0;
      unitIrq <= 8'h00;
    end else begin
      irq     <= |(evtStatus_q & evtMask_q);
      unitIrq <= intFlag_q & intEnable_q;
    end
  end

  // Pin outputs.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      serialClkOut  <= 1'b0;
      serialClkOe   <= 1'b0;
      serialDataOut <= 1'b0;
      serialDataOe  <= 1'b0;
    end else begin
      serialClkOut  <= isMaster && engState_q == ENG_RUN && phase_q;
      serialClkOe   <= isMaster && !softRst;
      serialDataOut <= txBit;
      serialDataOe  <= !softRst && (isMaster || slaveSel);
    end
  end

  // Read mux.
  logic [7:0] rdByte;
  logic       rdHit;
  always_comb begin
    rdHit  = 1'b1;
    rdByte = 8'h00;
    case (s_axi_araddr)
      ADDR_CONTROL_ONE:  rdByte = controlOne_q;
      ADDR_RATE_LOW:     rdByte = rateLow_q;
      ADDR_RATE_HIGH:    rdByte = rateHigh_q;
      ADDR_STATUS:       rdByte = {loopback_q, framingErr_q, overrunErr_q, 4'h0,
                                   engState_q == ENG_RUN};
      ADDR_RX_BUFFER:    rdByte = rxBuffer_q;
      ADDR_TX_BUFFER:    rdByte = sevenBit ? {1'b0, txBuffer_q[6:0]} : txBuffer_q;
      ADDR_PAIR0_ENABLE: rdByte = {4'h0, intEnable_q[3:0]};
      ADDR_PAIR0_FLAG:   rdByte = {4'h0, intFlag_q[3:0]};
      ADDR_PAIR1_ENABLE: rdByte = {4'h0, intEnable_q[7:4]};
      ADDR_PAIR1_FLAG:   rdByte = {4'h0, intFlag_q[7:4]};
      ADDR_MODE_CONFIG:  rdByte = {4'h0, modeConfig_q};
      ADDR_EVENT_STATUS: rdByte = {4'h0, evtStatus_q};
      ADDR_EVENT_MASK:   rdByte = {4'h0, evtMask_q};
      default:           rdHit  = 1'b0;
    endcase
  end

  logic wrHit;
  always_comb begin
    case (s_axi_awaddr)
      ADDR_CONTROL_ONE, ADDR_RATE_LOW, ADDR_RATE_HIGH, ADDR_STATUS, ADDR_RX_BUFFER,
      ADDR_TX_BUFFER, ADDR_PAIR0_ENABLE, ADDR_PAIR0_FLAG, ADDR_PAIR1_ENABLE,
      ADDR_PAIR1_FLAG, ADDR_MODE_CONFIG, ADDR_EVENT_STATUS, ADDR_EVENT_MASK: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  // Bus channels.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= wrFire;
      s_axi_wready  <= wrFire;
      if (wrFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= rdFire;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rdByte};
        s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : susc_top

// *** sim/susc_peer.sv ***
// SPI peer acting as a slave of the serial unit: shifts a byte out, collects the byte sent.
// Assumes mode 0 timing, clock idle low, least significant bit first.
`timescale 1ns/1ns
module susc_peer (
  input  wire logic       rst,
  input  wire logic       sclk,
  input  wire logic       sclkOe,
  input  wire logic       mosi,
  input  wire logic [7:0] txByte,
  input  wire logic       conflict,
  output logic            miso,
  output logic            selectN,
  output logic [7:0]      rxByte
);
  logic [2:0] idx;

  // The next bit goes out after each falling edge.
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      idx <= 3'h0;
    end else begin
      idx <= idx + 3'h1;
    end
  end

  // The unit's bit is taken on each rising edge.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rxByte <= 8'h00;
    end else begin
      rxByte <= {mosi, rxByte[7:1]};
    end
  end

  // A line whose clock is not driven shows the inverse of its last bit.
  assign miso    = sclkOe ? txByte[idx] : ~txByte[idx];
  assign selectN = ~conflict;
endmodule : susc_peer

// *** sim/susc_top_chk.sv ***
// Checker for the register bus, interrupt and serial clock outputs of the serial unit.
// Assumes it is bound to susc_top and sees only its ports.
`timescale 1ns/1ns
module susc_chk
  import susc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        serialClkOut,
  input wire logic        serialClkOe,
  input wire logic [7:0]  unitIrq,
  input wire logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence wrTake;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  endsequence
  sequence wrAns;
    s_axi_awready && s_axi_wready && s_axi_bvalid ##1 !s_axi_awready && !s_axi_wready;
  endsequence

  write_answer_a: assert property (wrTake |=> wrAns)
    else $error("write not answered one cycle after it was taken");
  read_answer_a: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready && s_axi_rvalid ##1 !s_axi_arready)
    else $error("read not answered one cycle after it was taken");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was accepted");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before it was accepted");
  rdata_width_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  unmapped_zero_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read returned data");
  reset_quiet_a: assert property ($fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && unitIrq == 8'h00)
    else $error("outputs active right after reset");
  sclk_owned_a: assert property ($changed(serialClkOut) |-> serialClkOe || $past(serialClkOe))
    else $error("serial clock moved while not driven");
endmodule : susc_chk

bind susc_top susc_chk susc_chk_i (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serialClkOut, .serialClkOe,
  .unitIrq, .irq);

// *** sim/test_serial_unit_spi_control_status.sv ***
// Self-checking bench for the serial unit: register table, interrupts and SPI transfers.
// Assumes susc_top, the peer model and the bound checker are compiled before it.
`timescale 1ns/1ns
module test_serial_unit_spi_control_status import susc_pkg::*;;
  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic [7:0] data;
    logic [7:0] want;
    logic [1:0] resp;
  } susc_row_t;

  logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, auxClkIn, subMainClkIn, serialClkIn, serialClkOut, serialClkOe;
  logic        slaveEnableInN, serialDataIn, serialDataOut, serialDataOe, irq, conflict;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, otherRxDone, otherTxEmpty, unitIrq;
  logic [7:0]  peerTx, peerRx, lastData;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lastResp;
  logic [2:0]  srcDiv;
  int          miscompares, total_checks, n;

  susc_row_t rows [15] = '{
    '{ADDR_CONTROL_ONE, 1'b0, 8'h00, 8'h01, RESP_OKAY},
    '{ADDR_STATUS, 1'b0, 8'h00, 8'h00, RESP_OKAY},
    '{ADDR_PAIR0_FLAG, 1'b0, 8'h00, 8'h0E, RESP_OKAY},
    '{ADDR_PAIR1_FLAG, 1'b0, 8'h00, 8'h0E, RESP_OKAY},
    '{ADDR_PAIR0_FLAG, 1'b1, 8'h00, 8'h00, RESP_OKAY},
    '{ADDR_PAIR0_FLAG, 1'b0, 8'h00, 8'h02, RESP_OKAY},
    '{ADDR_PAIR1_FLAG, 1'b1, 8'h00, 8'h00, RESP_OKAY},
    '{ADDR_PAIR1_FLAG, 1'b0, 8'h00, 8'h00, RESP_OKAY},
    '{ADDR_PAIR0_ENABLE, 1'b1, 8'hFF, 8'h00, RESP_OKAY},
    '{ADDR_PAIR0_ENABLE, 1'b0, 8'h00, 8'h0F, RESP_OKAY},
    '{ADDR_PAIR1_ENABLE, 1'b1, 8'hFF, 8'h00, RESP_OKAY},
    '{ADDR_PAIR1_ENABLE, 1'b0, 8'h00, 8'h0F, RESP_OKAY},
    '{ADDR_RATE_LOW, 1'b1, 8'h02, 8'h00, RESP_OKAY},
    '{ADDR_RATE_LOW, 1'b0, 8'h00, 8'h02, RESP_OKAY},
    '{8'h3C, 1'b1, 8'h5A, 8'h00, RESP_SLVERR}
  };

  susc_top susc_top_i (.*);
  susc_peer susc_peer_i (.rst(rst), .sclk(serialClkOut), .sclkOe(serialClkOe),
    .mosi(serialDataOut), .txByte(peerTx), .conflict(conflict), .miso(serialDataIn),
    .selectN(slaveEnableInN), .rxByte(peerRx));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Sub-main source runs at half the bench clock, auxiliary at an eighth.
  assign subMainClkIn = srcDiv[0];
  assign auxClkIn     = srcDiv[2];
  always @(posedge clk) srcDiv <= srcDiv + 3'h1;

  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    s_axi_bready <= 1'b1;
    @(posedge clk);
    lastResp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    s_axi_rready <= 1'b1;
    @(posedge clk);
    lastData = s_axi_rdata[7:0];
    lastResp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic xfer(input logic [7:0] tx);
    wr(ADDR_TX_BUFFER, tx);
    rd(ADDR_STATUS);
    chk(lastData & 8'h01, 8'h01);
    for (n = 0; n < 2000 && irq !== 1'b1; n++) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    wr(ADDR_EVENT_STATUS, 8'h01);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00);
    $display("transfer of %h done", tx);
  endtask : xfer

  initial begin
    rst = 1'b1;
    srcDiv = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    serialClkIn = 1'b0;
    otherRxDone = 8'h44;
    otherTxEmpty = 8'h00;
    peerTx = 8'h3C;
    conflict = 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    otherRxDone <= 8'h00;
    foreach (rows[i]) begin
      if (rows[i].write) wr(rows[i].addr, rows[i].data);
      else begin
        rd(rows[i].addr);
        chk(lastData, rows[i].want);
      end
      chk({6'h00, lastResp}, {6'h00, rows[i].resp});
    end
    $display("register table done");
    wr(ADDR_EVENT_MASK, 8'h01);
    wr(ADDR_MODE_CONFIG, 8'h01);
    wr(ADDR_CONTROL_ONE, 8'h80);
    xfer(8'h96);
    chk(peerRx, 8'h96);
    chk(unitIrq, 8'h03);
    rd(ADDR_RX_BUFFER);
    chk(lastData, 8'h3C);
    chk(unitIrq, 8'h02);
    $display("master transfer done");
    peerTx <= 8'hA5;
    conflict <= 1'b1;
    wr(ADDR_MODE_CONFIG, 8'h05);
    wr(ADDR_CONTROL_ONE, 8'h40);
    xfer(8'h5A);
    xfer(8'hC3);
    chk(peerRx, 8'hC3);
    rd(ADDR_STATUS);
    chk(lastData, 8'h60);
    rd(ADDR_RX_BUFFER);
    chk(lastData, 8'hA5);
    rd(ADDR_STATUS);
    chk(lastData, 8'h00);
    conflict <= 1'b0;
    $display("overrun and conflict done");
    peerTx <= 8'hFF;
    wr(ADDR_MODE_CONFIG, 8'h03);
    wr(ADDR_CONTROL_ONE, 8'hC0);
    wr(ADDR_STATUS, 8'h80);
    xfer(8'hB5);
    rd(ADDR_TX_BUFFER);
    chk(lastData, 8'h35);
    rd(ADDR_RX_BUFFER);
    chk(lastData, 8'h35);
    $display("seven-bit loopback done");
    wr(ADDR_MODE_CONFIG, 8'h08);
    wr(ADDR_CONTROL_ONE, 8'h00);
    wr(ADDR_TX_BUFFER, 8'hC6);
    chk({6'h00, serialClkOe, serialDataOe}, 8'h01);
    repeat (8) begin
      repeat (4) @(posedge clk);
      serialClkIn <= 1'b1;
      repeat (4) @(posedge clk);
      serialClkIn <= 1'b0;
    end
    repeat (4) @(posedge clk);
    rd(ADDR_RX_BUFFER);
    chk(lastData, 8'hC6);
    $display("slave loopback done");
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_CONTROL_ONE);
    chk(lastData, 8'h01);
    rd(ADDR_PAIR0_FLAG);
    chk(lastData, 8'h0A);
    chk({6'h00, serialClkOe, serialDataOe}, 8'h00);
    $display("second reset done");
    results();
  end

  // The whole sequence needs about a thousand cycles; twenty thousand means a hang.
  initial begin
    #200000;
    miscompares++;
    results();
  end
endmodule : test_serial_unit_spi_control_status
